// ==== core/ddr3_mode_config.v ====
// mode register decode and burst sequencing for the memory device core
// Summary of operation
// (R01) MRS with all bank bits low loads MR0 from address pins.
// (R02) MRS with bank bit 0 high, others low, loads MR1.
// (R03) Controller drives reserved MR0 positions to zero.
// (R04) Controller drives reserved MR1 positions to zero.
// (R05) Controller programs write recovery at least ceil(tWR / tCK).
// (R06) Auto-precharge write delay is write recovery plus precharge period.
// (R07) Read burst order follows start column and sequential or interleaved type.
// (R08) Chopped read drives four beats then releases data and strobe drivers.
// (R09) Writes use fixed order; chop uses column bit 2 for group.
// (R10) Fixed four-beat mode pulls internal write reference two clocks earlier.
// (R11) On-the-fly chop keeps the eight-beat write reference point.
// (R12) Read data starts whole CAS-latency clocks after internal read; RL=AL+CL.
// (R13) Controller keeps MR0 test mode bit at zero.
// (R14) DLL reset bit clears itself once the reset pulse is issued.
// (R15) Controller waits DLL lock with clock enable high after reset.
// (R16) MR0 bit 12 chooses slow exit (DLL frozen) or fast exit.
// (R17) DLL turns off on self-refresh entry and back on at exit.
// (R18) Controller disables termination while in DLL-off mode.
// (R19) Write leveling without output disable limits nominal termination choices.
// (R20) Write termination applies during writes with ODT even without nominal.
// (R21) Output disable releases data and both strobe drivers.
// (R22) Controller sends only NOP or deselect between init MRS and ZQCL.
// (R23) Posted read or write waits additive latency before executing.
// (R24) Output disable is MR1 bit 12; one disconnects, zero normal.
// (R25) Mode registers hold their value until the next MRS addressing them.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`include "ddr3_mode_map.vh"
`default_nettype none
module ddr3_mode_config #(
   parameter RP_CYCLES = 8
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire ck_i,
   input wire cke_i,
   input wire cs_b_i,
   input wire ras_b_i,
   input wire cas_b_i,
   input wire we_b_i,
   input wire [2:0] ba_i,
   input wire [13:0] addr_i,
   input wire odt_i,
   output reg dq_oe_o,
   output reg dqs_oe_o,
   output reg [2:0] beat_idx_o,
   output reg wr_beat_o,
   output reg wr_ref_o,
   output reg [1:0] rtt_sel_o,
   output reg dll_on_o,
   output reg dll_rst_o,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_BURST = 2'h2;
   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------
   function [4:0] cl_dec;
      input [13:0] m;
      cl_dec = {1'b0, (m[2] ? `CL_BASE_HI : `CL_BASE_LO)} + {2'h0, m[6:4]};
   endfunction
   function [4:0] wr_dec;
      input [2:0] f;
      wr_dec = (f == 3'h0) ? `WR_MAX :
               (f < 3'h5) ? `WR_MIN + {2'h0, f} - 5'h01 : {1'b0, f, 1'b0};
   endfunction
   function [2:0] beat_ord;
      input [2:0] st;
      input [2:0] n;
      input intl;
      beat_ord = intl ? (st ^ n) : {st[2] ^ n[2], st[1:0] + n[1:0]};
   endfunction

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   localparam PW = 24;
   reg [PW-1:0] pin_s1_r;
   reg [PW-1:0] pin_s2_r;
   reg ck_d_r;
   wire [PW-1:0] pin_raw = {ck_i, cke_i, cs_b_i, ras_b_i, cas_b_i, we_b_i, ba_i, addr_i, odt_i};
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_s1_r <= {PW{1'b1}};
         pin_s2_r <= {PW{1'b1}};
         ck_d_r <= 1'b1;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         ck_d_r <= pin_s2_r[23];
      end
   end
   wire ck_s = pin_s2_r[23];
   wire ck_rise = ck_s & ~ck_d_r;
   wire ck_edge = ck_s ^ ck_d_r;
   wire cke_s = pin_s2_r[22];
   wire [3:0] cmd = pin_s2_r[21:18];
   wire [2:0] ba_s = pin_s2_r[17:15];
   wire [13:0] a_s = pin_s2_r[14:1];
   wire odt_s = pin_s2_r[0];
   wire is_mrs = ck_rise & cke_s & (cmd == 4'h0);
   wire is_rd = ck_rise & cke_s & (cmd == 4'h5);
   wire is_wr = ck_rise & cke_s & (cmd == 4'h4);
   wire is_sre = ck_rise & ~cke_s & (cmd == 4'h1);

   // ----------------------------------------------------------------------
   // mode registers and power state
   // ----------------------------------------------------------------------
   reg [13:0] mr0_r;
   reg [13:0] mr1_r;
   reg [31:0] ctrl_r;
   reg self_ref_r;
   reg pdn_r;
   reg cke_d_r;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mr0_r <= `MR0_RST;
         mr1_r <= `MR1_RST;
         dll_rst_o <= 1'b0;
         self_ref_r <= 1'b0;
         pdn_r <= 1'b0;
         cke_d_r <= 1'b0;
         dll_on_o <= 1'b0;
      end else begin
         dll_rst_o <= 1'b0;
         if (is_mrs && ba_s == 3'h0) begin
            mr0_r <= a_s; // R01 R25
            dll_rst_o <= a_s[`MR0_DLLRST];
         end else if (mr0_r[`MR0_DLLRST]) begin
            mr0_r[`MR0_DLLRST] <= 1'b0; // R14
         end
         if (is_mrs && ba_s == 3'h1)
            mr1_r <= a_s; // R02 R25
         if (ck_rise) begin
            cke_d_r <= cke_s;
            if (is_sre)
               self_ref_r <= 1'b1; // R17
            else if (cke_s)
               self_ref_r <= 1'b0; // R17
            pdn_r <= ~cke_s & ~is_sre & ~self_ref_r & cke_d_r ? 1'b1 : (cke_s ? 1'b0 : pdn_r);
         end
         // frozen in slow-exit power-down, off in self refresh
         dll_on_o <= ~mr1_r[`MR1_DLLDIS] & ~self_ref_r
                     & ~(pdn_r & ~mr0_r[`MR0_PPD]); // R16 R17
      end
   end

   // ----------------------------------------------------------------------
   // posted command and burst sequencing
   // ----------------------------------------------------------------------
   wire [4:0] cl = cl_dec(mr0_r);
   wire [4:0] cwl = ctrl_r[4:0];
   wire [4:0] al = (mr1_r[4:3] == `AL_CLM1) ? cl - 5'h01 :
                   (mr1_r[4:3] == `AL_CLM2) ? cl - 5'h02 : 5'h00;
   wire [5:0] tdal = {1'b0, wr_dec(mr0_r[11:9])} + RP_CYCLES[5:0]; // R06
   wire fix4 = mr0_r[1:0] == `BL_FIX4;
   wire otf = mr0_r[1:0] == `BL_OTF;
   wire qoff = mr1_r[`MR1_QOFF];
   reg [1:0] st_r;
   reg [5:0] wait_r;
   reg [2:0] beat_r;
   reg [2:0] start_r;
   reg chop_r;
   reg is_wr_r;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= ST_IDLE;
         wait_r <= 6'h00;
         beat_r <= 3'h0;
         start_r <= 3'h0;
         chop_r <= 1'b0;
         is_wr_r <= 1'b0;
         dq_oe_o <= 1'b0;
         dqs_oe_o <= 1'b0;
         beat_idx_o <= 3'h0;
         wr_beat_o <= 1'b0;
         wr_ref_o <= 1'b0;
         rtt_sel_o <= 2'h0;
      end else begin
         wr_ref_o <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (is_rd || is_wr) begin
                  st_r <= ST_WAIT;
                  is_wr_r <= is_wr;
                  // additive latency then CAS latency, or CAS write latency for writes, whole clocks only
                  wait_r <= {1'b0, al} + {1'b0, is_wr ? cwl : cl}; // R23 R12
                  start_r <= is_wr ? {a_s[2] & (fix4 | (otf & ~a_s[12])), 2'h0} : a_s[2:0]; // R09
                  chop_r <= fix4 | (otf & ~a_s[12]);
               end
            end
            ST_WAIT: begin
               if (ck_rise) begin
                  if (wait_r <= 6'h01) begin
                     st_r <= ST_BURST;
                     beat_r <= 3'h0;
                  end
                  wait_r <= wait_r - 6'h01;
               end
            end
            ST_BURST: begin
               if (ck_edge) begin
                  beat_r <= beat_r + 3'h1;
                  if (beat_r == `BEATS_BL8)
                     st_r <= ST_IDLE;
                  // write reference moves in only for fixed four-beat mode
                  if (is_wr_r && ((fix4 && beat_r == `BEATS_BC4) // R10
                      || (!fix4 && beat_r == `BEATS_BL8))) // R11
                     wr_ref_o <= 1'b1;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
         if (st_r == ST_BURST && !is_wr_r)
            beat_idx_o <= beat_ord(start_r, beat_r, mr0_r[`MR0_BT]); // R07
         else
            beat_idx_o <= start_r + beat_r; // R09
         dq_oe_o <= st_r == ST_BURST && !is_wr_r && !qoff
                    && !(chop_r && beat_r[2]); // R08 R21 R24
         dqs_oe_o <= st_r == ST_BURST && !is_wr_r && !qoff
                     && !(chop_r && beat_r[2]); // R08 R21
         wr_beat_o <= st_r == ST_BURST && is_wr_r && !(chop_r && beat_r[2]);
         if (!odt_s || self_ref_r)
            rtt_sel_o <= 2'h0;
         else if (st_r != ST_IDLE && is_wr_r && ctrl_r[6:5] != 2'h0)
            rtt_sel_o <= 2'h2; // R20
         else if ({mr1_r[9], mr1_r[6], mr1_r[2]} != 3'h0)
            rtt_sel_o <= 2'h1;
         else
            rtt_sel_o <= 2'h0;
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite register access
   // ----------------------------------------------------------------------
   reg aw_hit_r;
   reg w_hit_r;
   reg [3:0] awa_r;
   reg [31:0] wd_r;
   reg [3:0] ws_r;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OK;
         aw_hit_r <= 1'b0;
         w_hit_r <= 1'b0;
         awa_r <= 4'h0;
         wd_r <= 32'h0000_0000;
         ws_r <= 4'h0;
         ctrl_r <= `CTRL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hit_r <= 1'b1;
            awa_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hit_r <= 1'b1;
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_hit_r && w_hit_r && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            aw_hit_r <= 1'b0;
            w_hit_r <= 1'b0;
            if (awa_r == `OFS_CTRL && ws_r[0])
               ctrl_r[7:0] <= wd_r[7:0];
            if (awa_r == `OFS_CTRL || awa_r == `OFS_MR0
                || awa_r == `OFS_MR1 || awa_r == `OFS_STAT)
               s_axi_bresp <= `RESP_OK;
            else
               s_axi_bresp <= `RESP_ERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OK;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OK;
            case (s_axi_araddr)
               `OFS_CTRL: s_axi_rdata <= {24'h000000, ctrl_r[7:0]};
               `OFS_MR0: s_axi_rdata <= {18'h00000, mr0_r};
               `OFS_MR1: s_axi_rdata <= {18'h00000, mr1_r};
               `OFS_STAT: s_axi_rdata <= {16'h0000, 2'h0, tdal, 3'h0, pdn_r,
                                          self_ref_r, dll_on_o, st_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RESP_ERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // ddr3_mode_config
`default_nettype wire

// ==== core/ddr3_mode_map.vh ====
// constants for the mode register configuration block
`ifndef DDR3_MODE_MAP_VH
`define DDR3_MODE_MAP_VH
// ----------------------------------------------------------------------
// register offsets on the AXI4-Lite side
// ----------------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_MR0 4'h4
`define OFS_MR1 4'h8
`define OFS_STAT 4'hC
`define CTRL_RST 32'h0000_0005
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
// ----------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------
`define MR_W 14
`define MR0_RST 14'h0000
`define MR1_RST 14'h0001
`define MR0_BT 3
`define MR0_TM 7
`define MR0_DLLRST 8
`define MR0_PPD 12
`define MR1_DLLDIS 0
`define MR1_WLVL 7
`define MR1_QOFF 12
`define BL_FIX8 2'h0
`define BL_OTF 2'h1
`define BL_FIX4 2'h2
`define AL_CLM1 2'h1
`define AL_CLM2 2'h2
// ----------------------------------------------------------------------
// latency decode
// ----------------------------------------------------------------------
`define CL_BASE_LO 4'h4
`define CL_BASE_HI 4'hC
`define WR_MIN 5'h05
`define WR_MAX 5'h10
`define BEATS_BC4 3'h3
`define BEATS_BL8 3'h7
`endif

// ==== tb/ddr3_ctl_model.sv ====
// memory controller stand-in driving the command pins
`default_nettype none
module ddr3_ctl_model (
   output var logic ck_o,
   output var logic cke_o,
   output var logic cs_b_o,
   output var logic ras_b_o,
   output var logic cas_b_o,
   output var logic we_b_o,
   output var logic [2:0] ba_o,
   output var logic [13:0] addr_o,
   output var logic odt_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      ck_o = 1'b1;
      cke_o = 1'b1;
      {cs_b_o, ras_b_o, cas_b_o, we_b_o, ba_o, addr_o, odt_o} = 22'h3C0000;
      #3;
      forever #32 ck_o = ~ck_o;
   end
   // pins move at the fall so they are steady around the sampled rise
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
      input logic o);
      @(negedge ck_o);
      {cs_b_o, ras_b_o, cas_b_o, we_b_o} = c;
      ba_o = b;
      addr_o = a;
      if (c == 4'h0 && b == 3'h0) addr_o = a & 14'h1F7F;
      if (c == 4'h0 && b == 3'h1) addr_o = a & 14'h1AFF;
      odt_o = o && !(c == 4'h0 && b == 3'h1 && a[0]);
      @(negedge ck_o);
      {cs_b_o, ras_b_o, cas_b_o, we_b_o} = 4'hF;
      ba_o = ~b;
      addr_o = ~a;
      @(negedge ck_o);
   endtask
   // clock enable moves at the fall like the command pins
   task automatic set_cke(input logic v);
      @(negedge ck_o);
      cke_o = v;
      @(negedge ck_o);
   endtask
endmodule // ddr3_ctl_model
`default_nettype wire

// ==== tb/ddr3_mode_config_properties.sv ====
// port assertions for the mode register block
`default_nettype none
module ddr3_mode_config_properties #(
   parameter RP_CYCLES = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic odt_i,
   input wire logic dq_oe_o,
   input wire logic dqs_oe_o,
   input wire logic wr_beat_o,
   input wire logic wr_ref_o,
   input wire logic [1:0] rtt_sel_o,
   input wire logic dll_rst_o,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   oe_pair_a: assert property (dq_oe_o == dqs_oe_o) else $error("oe pair");
   dir_apart_a: assert property (wr_beat_o |-> !dq_oe_o) else $error("oe in write");
   dll_pulse_a: assert property (dll_rst_o |=> !dll_rst_o) else $error("dll pulse");
   ref_pulse_a: assert property (wr_ref_o |=> !wr_ref_o) else $error("ref pulse");
   // odt passes two flops and a register, five cycles leaves margin
   term_off_a: assert property (!odt_i [*5] |-> rtt_sel_o == 2'h0) else $error("rtt");
   wr_resp_a: assert property (wr_taken |=> wr_answer) else $error("bvalid time");
   wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("b retire");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("rvalid time");
endmodule // ddr3_mode_config_properties
bind ddr3_mode_config ddr3_mode_config_properties #(.RP_CYCLES(RP_CYCLES)) props_i (
   .clk_i, .rst_b_i, .odt_i, .dq_oe_o, .dqs_oe_o, .wr_beat_o, .wr_ref_o, .rtt_sel_o,
   .dll_rst_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);
`default_nettype wire

// ==== tb/tb.sv ====
// bench for the mode register block
`include "ddr3_mode_map.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RP = 4;
   logic clk_i, rst_b_i, ck_i, cke_i, cs_b_i, ras_b_i, cas_b_i, we_b_i, odt_i, oe_q, wb_q;
   logic dq_oe_o, dqs_oe_o, wr_beat_o, wr_ref_o, dll_on_o, dll_rst_o;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] rtt_sel_o, s_axi_bresp, s_axi_rresp, r, rtt_w;
   logic [2:0] ba_i, beat_idx_o, bi_q;
   logic [2:0] q[$];
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [13:0] addr_i;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   int n_fail, n_checks, cyc, t0, gap, n_rst;
   typedef struct packed {
      logic [13:0] mr0;
      logic [13:0] mr1;
      logic wr;
      logic [13:0] a;
      logic [3:0] n;
   } row_t;
   // recovery field 0 is the longest setting, safe at any clock
   // write leveling stays off, so every termination code is allowed
   row_t rows [7] = '{
      '{14'h0110, 14'h0000, 1'b0, 14'h0003, 4'h8},
      '{14'h0018, 14'h0000, 1'b0, 14'h0005, 4'h8},
      '{14'h0012, 14'h0000, 1'b0, 14'h0006, 4'h4},
      '{14'h0010, 14'h1000, 1'b0, 14'h0000, 4'h0},
      '{14'h0012, 14'h0000, 1'b1, 14'h0006, 4'h4},
      '{14'h0010, 14'h0000, 1'b1, 14'h0007, 4'h8},
      '{14'h0011, 14'h0000, 1'b1, 14'h0002, 4'h4}
   };
   ddr3_ctl_model ctl_i (.ck_o(ck_i), .cke_o(cke_i), .cs_b_o(cs_b_i), .ras_b_o(ras_b_i),
      .cas_b_o(cas_b_i), .we_b_o(we_b_i), .ba_o(ba_i), .addr_o(addr_i), .odt_o(odt_i));
   ddr3_mode_config #(.RP_CYCLES(RP)) ddr3_mode_config_i (.clk_i, .rst_b_i, .ck_i, .cke_i,
      .cs_b_i, .ras_b_i, .cas_b_i, .we_b_i, .ba_i, .addr_i, .odt_i, .dq_oe_o, .dqs_oe_o,
      .beat_idx_o, .wr_beat_o, .wr_ref_o, .rtt_sel_o, .dll_on_o, .dll_rst_o, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // beat log: one entry per new beat index while a burst is on
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      oe_q <= dq_oe_o;
      wb_q <= wr_beat_o;
      bi_q <= beat_idx_o;
      if ((dq_oe_o || wr_beat_o) && (!(oe_q || wb_q) || beat_idx_o != bi_q))
         q.push_back(beat_idx_o);
      if (wr_beat_o && !wb_q) t0 <= cyc;
      if (wr_beat_o) rtt_w <= rtt_sel_o;
      if (wr_ref_o) gap <= cyc - t0;
      if (dll_rst_o) n_rst <= n_rst + 1;
      if (dq_oe_o || dqs_oe_o) chk(dqs_oe_o, dq_oe_o);
   end
   function automatic logic [2:0] nth(row_t w, int k);
      if (w.wr)
         return {w.a[2] & (w.n == 4'h4), 2'h0} + k[2:0];
      if (w.mr0[3])
         return w.a[2:0] ^ k[2:0];
      return {w.a[2] ^ k[2], w.a[1:0] + k[1:0]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clk_i);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      while (s_axi_bvalid !== 1'b1) @(posedge clk_i);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk_i);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge clk_i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #40000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      rst_b_i = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {12'h00F, 32'h0};
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      axi_rd(`OFS_CTRL, d, r);
      chk(d, `CTRL_RST);
      axi_wr(`OFS_CTRL, 32'h0000_0025, r);
      chk(r, `RESP_OK);
      foreach (rows[i]) begin
         ctl_i.cmd(4'h0, 3'h1, rows[i].mr1, 1'b0);
         ctl_i.cmd(4'h0, 3'h0, rows[i].mr0, 1'b0);
         axi_rd(`OFS_MR0, d, r);
         chk(d, {18'h0, rows[i].mr0 & 14'h3EFF});
         axi_rd(`OFS_MR1, d, r);
         chk(d, {18'h0, rows[i].mr1});
         chk(dll_on_o, 1'b1);
         q.delete();
         ctl_i.cmd(rows[i].wr ? 4'h4 : 4'h5, 3'h0, rows[i].a, rows[i].wr);
         repeat (120) @(posedge clk_i);
         chk(q.size(), rows[i].n);
         foreach (q[k]) chk(q[k], nth(rows[i], k));
         if (rows[i].wr) begin
            chk(gap < 24, rows[i].mr0[1:0] == `BL_FIX4);
            chk(rtt_w, 2'h2);
         end
         $display("row %0d done", i);
      end
      chk(n_rst, 1);
      ctl_i.cmd(4'h0, 3'h2, 14'h1234, 1'b0);
      axi_wr(`OFS_MR0, 32'h0000_3FFF, r);
      chk(r, `RESP_OK);
      axi_rd(`OFS_MR0, d, r);
      chk(d, 32'h0000_0011);
      axi_rd(`OFS_STAT, d, r);
      chk(d[13:8], 16 + RP);
      axi_rd(4'h2, d, r);
      chk(r, `RESP_ERR);
      $display("refusal test done");
      ctl_i.set_cke(1'b0);
      repeat (8) @(posedge clk_i);
      axi_rd(`OFS_STAT, d, r);
      chk(d[4:2], 3'h4);
      ctl_i.cmd(4'h1, 3'h0, 14'h0000, 1'b0);
      axi_rd(`OFS_STAT, d, r);
      chk(d[4:2], 3'h6);
      ctl_i.set_cke(1'b1);
      repeat (8) @(posedge clk_i);
      chk(dll_on_o, 1'b1);
      ctl_i.cmd(4'h0, 3'h0, 14'h1011, 1'b0);
      ctl_i.set_cke(1'b0);
      repeat (8) @(posedge clk_i);
      axi_rd(`OFS_STAT, d, r);
      chk(d[4:2], 3'h5);
      ctl_i.set_cke(1'b1);
      $display("power test done");
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      axi_rd(`OFS_MR0, d, r);
      chk(d, {18'h0, `MR0_RST});
      axi_rd(`OFS_MR1, d, r);
      chk(d, {18'h0, `MR1_RST});
      chk(dll_on_o, 1'b0);
      $display("reset test done");
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
